// ===== logic/lcr_regs.sv
// control and status register group of the line codec
// assumes an avalon-mm master on sys_clk, word addressing, data in bits 7:0
// assumes timer events and indirect requests are pulses on sys_clk
// assumes alarm and line events are asynchronous levels
`timescale 1ns/1ps
module lcr_regs
   import lcr_pkg::*;
#(
   parameter int TICK_CYCLES = LCR_IND_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   // event sources
   input wire logic [5:0] timer_events,
   input wire logic [7:0] alarm_line_events,
   input wire logic indirect_request,
   // automatic power decisions from the sequencer
   input wire logic adc_auto_on,
   input wire logic dac_auto_on,
   input wire logic transamp_auto_on,
   // hybrid controls
   output logic [2:0] metering_hybrid_gain,
   output logic [2:0] audio_hybrid_gain,
   output logic metering_hybrid_off,
   output logic audio_hybrid_off,
   // overrides
   output logic converter_force_off,
   output logic pll_force_freerun,
   output logic bias_force_off,
   output logic line_driver_force_off,
   // resolved converter and amplifier power
   output logic adc_power_en,
   output logic dac_power_en,
   output logic transamp_power_en,
   // indirect update strobe
   output logic indirect_service
);

   if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
      $error("lcr_regs tick count out of range");
   end

   // bus handshake

   lcr_bus_state_t bus_q; // handshake state
   lcr_bus_state_t bus_d;
   logic wait_q; // registered waitrequest
   logic [7:0] rdata_q; // registered read byte

   wire bus_req = avs_read | avs_write; // request present
   wire commit = avs_write & (bus_q == LCR_BUS_ACK); // write lands here
   wire wr_lane = commit & avs_byteenable[0]; // low byte written
   wire [7:0] wdata = avs_writedata[7:0]; // write byte

   // address hit, used by every register
   function automatic logic hit(input logic [5:0] addr, input logic [5:0] idx);
      hit = (addr == idx);
   endfunction

   // per register write strobes
   wire wr_hyb = wr_lane & hit(avs_address, LCR_IDX_HYBRID);
   wire wr_pd1 = wr_lane & hit(avs_address, LCR_IDX_PD1);
   wire wr_pd2 = wr_lane & hit(avs_address, LCR_IDX_PD2);
   wire wr_irq1 = wr_lane & hit(avs_address, LCR_IDX_IRQ1);
   wire wr_irq2 = wr_lane & hit(avs_address, LCR_IDX_IRQ2);
   wire wr_irq3 = wr_lane & hit(avs_address, LCR_IDX_IRQ3);
   wire wr_en1 = wr_lane & hit(avs_address, LCR_IDX_EN1);
   wire wr_en2 = wr_lane & hit(avs_address, LCR_IDX_EN2);
   wire wr_en3 = wr_lane & hit(avs_address, LCR_IDX_EN3);

   // handshake next state
   always_comb begin
      bus_d = bus_q;
      case (bus_q)
         LCR_BUS_IDLE: begin
            // a request gets one wait cycle
            if (bus_req) begin
               bus_d = LCR_BUS_ACK;
            end
         end
         LCR_BUS_ACK: begin
            // waitrequest low this cycle, access completes
            bus_d = LCR_BUS_DONE;
         end
         LCR_BUS_DONE: begin
            // one idle cycle so a held request is not taken twice
            bus_d = LCR_BUS_IDLE;
         end
         default: begin
            bus_d = LCR_BUS_IDLE;
         end
      endcase
   end

   // handshake registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_q <= LCR_BUS_IDLE;
         wait_q <= 1'b1;
      end else begin
         bus_q <= bus_d;
         wait_q <= (bus_d != LCR_BUS_ACK);
      end
   end

   // control registers

   logic [7:0] hyb_q; // hybrid balance control
   logic [7:0] pd1_q; // powerdown override control
   logic [7:0] pd2_q; // converter power control
   logic [7:0] en1_q; // timer enables
   logic [7:0] en2_q; // alarm and line enables
   logic [7:0] en3_q; // indirect enable

   // plain read-write registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hyb_q <= LCR_RST_HYBRID;
         pd1_q <= LCR_RST_PD1;
         pd2_q <= LCR_RST_PD2;
         en1_q <= LCR_RST_EN;
         en2_q <= LCR_RST_EN;
         en3_q <= LCR_RST_EN;
      end else begin
         if (wr_hyb) begin
            hyb_q <= wdata & LCR_MASK_HYBRID;
         end
         if (wr_pd1) begin
            pd1_q <= wdata & LCR_MASK_PD1;
         end
         if (wr_pd2) begin
            pd2_q <= wdata & LCR_MASK_PD2;
         end
         if (wr_en1) begin
            en1_q <= wdata & LCR_MASK_IRQ1;
         end
         if (wr_en2) begin
            en2_q <= wdata & LCR_MASK_IRQ2;
         end
         if (wr_en3) begin
            en3_q <= wdata & LCR_MASK_IRQ3;
         end
      end
   end

   // indirect update tick

   logic [15:0] tick_cnt_q; // cycles within one update period
   logic req_wait_q; // a request awaits the next update
   logic svc_q; // service strobe register

   wire tick = (tick_cnt_q == 16'(TICK_CYCLES - 1)); // update instant

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 16'h0000;
         req_wait_q <= 1'b0;
         svc_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
         svc_q <= tick & (req_wait_q | indirect_request);
         // a request arriving on the tick is served there
         if (tick) begin
            req_wait_q <= 1'b0;
         end else if (indirect_request) begin
            req_wait_q <= 1'b1;
         end
      end
   end

   // pending flags

   wire [7:0] alarm_rise; // synced alarm and line edges
   wire [5:0] pend1; // timer pending flags
   wire [7:0] pend2; // alarm and line pending flags
   wire [0:0] pend3; // indirect done flag

   // edges of asynchronous alarm levels
   lcr_sync_edge #(
      .WIDTH(8)
   ) u_alarm_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(alarm_line_events),
      .rise_pulse(alarm_rise)
   );

   // timer flags bits 5 to 0
   lcr_pend_bank #(
      .WIDTH(6)
   ) u_pend1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_pulse(timer_events),
      .clr_pulse({6{wr_irq1}} & wdata[5:0]),
      .pend(pend1)
   );

   lcr_pend_bank #(
      .WIDTH(8)
   ) u_pend2 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_pulse(alarm_rise),
      .clr_pulse({8{wr_irq2}} & wdata),
      .pend(pend2)
   );

   lcr_pend_bank #(
      .WIDTH(1)
   ) u_pend3 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_pulse(svc_q),
      .clr_pulse(wr_irq3 & wdata[LCR_IRQ3_IND]),
      .pend(pend3)
   );

   // status bytes as software sees them
   wire [7:0] stat1 = {2'b00, pend1};
   wire [7:0] stat2 = pend2;
   wire [7:0] stat3 = {6'b000000, pend3, 1'b0};

   // read path

   logic [7:0] rmux; // selected read byte

   // read select; unmapped reads return zero
   always_comb begin
      case (avs_address)
         LCR_IDX_HYBRID: rmux = hyb_q;
         LCR_IDX_PD1: rmux = pd1_q;
         LCR_IDX_PD2: rmux = pd2_q;
         LCR_IDX_IRQ1: rmux = stat1;
         LCR_IDX_IRQ2: rmux = stat2;
         LCR_IDX_IRQ3: rmux = stat3;
         LCR_IDX_EN1: rmux = en1_q;
         LCR_IDX_EN2: rmux = en2_q;
         LCR_IDX_EN3: rmux = en3_q;
         default: rmux = 8'h00;
      endcase
   end

   // read byte captured as waitrequest drops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (bus_q == LCR_BUS_IDLE && avs_read) begin
         rdata_q <= rmux;
      end
   end

   // interrupt output

   logic irq_q; // level interrupt

   wire irq_d = |(stat1 & en1_q) | |(stat2 & en2_q) | |(stat3 & en3_q);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // control outputs

   logic [2:0] met_gain_q; // metering gain code
   logic [2:0] aud_gain_q; // audio gain code
   logic met_off_q; // metering hybrid disabled
   logic aud_off_q; // audio hybrid disabled
   logic conv_off_q; // converter forced off
   logic pll_fr_q; // pll forced free-run
   logic bias_off_q; // bias forced off
   logic ldrv_off_q; // line driver forced off
   logic adc_en_q; // adc powered
   logic dac_en_q; // dac powered
   logic gm_en_q; // transamp powered

   wire [2:0] met_code = hyb_q[LCR_HYB_MET_LSB +: 3];
   wire [2:0] aud_code = hyb_q[LCR_HYB_AUD_LSB +: 3];

   wire adc_d = pd2_q[LCR_PD2_ADC_M] ? pd2_q[LCR_PD2_ADC_ON] : adc_auto_on;
   wire dac_d = pd2_q[LCR_PD2_DAC_M] ? pd2_q[LCR_PD2_DAC_ON] : dac_auto_on;
   wire gm_d = pd2_q[LCR_PD2_GM_M] ? pd2_q[LCR_PD2_GM_ON] : transamp_auto_on;

   // registered copies of every control
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         met_gain_q <= 3'h0;
         aud_gain_q <= 3'h0;
         met_off_q <= 1'b0;
         aud_off_q <= 1'b0;
         conv_off_q <= 1'b0;
         pll_fr_q <= 1'b0;
         bias_off_q <= 1'b0;
         ldrv_off_q <= 1'b0;
         adc_en_q <= 1'b0;
         dac_en_q <= 1'b0;
         gm_en_q <= 1'b0;
      end else begin
         met_gain_q <= met_code;
         aud_gain_q <= aud_code;
         met_off_q <= (met_code == LCR_HYB_OFF);
         aud_off_q <= (aud_code == LCR_HYB_OFF);
         conv_off_q <= pd1_q[LCR_PD1_CONV];
         pll_fr_q <= pd1_q[LCR_PD1_PLL];
         bias_off_q <= pd1_q[LCR_PD1_BIAS];
         ldrv_off_q <= pd1_q[LCR_PD1_LDRV];
         adc_en_q <= adc_d;
         dac_en_q <= dac_d;
         gm_en_q <= gm_d;
      end
   end

   // port drive, all from flops
   assign avs_readdata = {24'h000000, rdata_q};
   assign avs_waitrequest = wait_q;
   assign irq = irq_q;
   assign metering_hybrid_gain = met_gain_q;
   assign audio_hybrid_gain = aud_gain_q;
   assign metering_hybrid_off = met_off_q;
   assign audio_hybrid_off = aud_off_q;
   assign converter_force_off = conv_off_q;
   assign pll_force_freerun = pll_fr_q;
   assign bias_force_off = bias_off_q;
   assign line_driver_force_off = ldrv_off_q;
   assign adc_power_en = adc_en_q;
   assign dac_power_en = dac_en_q;
   assign transamp_power_en = gm_en_q;
   assign indirect_service = svc_q;

endmodule

// ===== inc/lcr_pkg.sv
// constants for the line codec control and status register group
// assumes a single 100 MHz clock and a word-addressed avalon-mm slave port
//
// Overview of operation
// - metering hybrid gain in bits 6:4, 111 off
// - audio hybrid gain in bits 2:0, 111 off
// - bit 4 forces dc-dc converter off
// - bit 3 forces pll into free-run
// - bit 1 forces dc bias circuitry off
// - bit 0 forces line driver off
// - adc manual bit 5, on bit 4
// - dac manual bit 3, on bit 2
// - transamp manual bit 1, on bit 0
// - timer pending flags occupy bits 5 to 0
// - writing one clears a pending flag
// - transistor alarm flags occupy bits 7 to 2
// - loop closure bit 1, ring trip bit 0
// - indirect done flag sets on service completion
// - enable bit per flag masks interrupt
// - indirect service happens at 16 kHz tick
package lcr_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] LCR_IDX_HYBRID = 6'h0b;
   localparam logic [5:0] LCR_IDX_PD1 = 6'h0e;
   localparam logic [5:0] LCR_IDX_PD2 = 6'h0f;
   localparam logic [5:0] LCR_IDX_IRQ1 = 6'h12;
   localparam logic [5:0] LCR_IDX_IRQ2 = 6'h13;
   localparam logic [5:0] LCR_IDX_IRQ3 = 6'h14;
   localparam logic [5:0] LCR_IDX_EN1 = 6'h15;
   localparam logic [5:0] LCR_IDX_EN2 = 6'h16;
   localparam logic [5:0] LCR_IDX_EN3 = 6'h17;

   // hybrid field positions
   localparam int LCR_HYB_MET_LSB = 4;
   localparam int LCR_HYB_AUD_LSB = 0;
   localparam logic [2:0] LCR_HYB_OFF = 3'h7;

   // powerdown control 1 bit positions
   localparam int LCR_PD1_CONV = 4;
   localparam int LCR_PD1_PLL = 3;
   localparam int LCR_PD1_BIAS = 1;
   localparam int LCR_PD1_LDRV = 0;

   // powerdown control 2 bit positions
   localparam int LCR_PD2_ADC_M = 5;
   localparam int LCR_PD2_ADC_ON = 4;
   localparam int LCR_PD2_DAC_M = 3;
   localparam int LCR_PD2_DAC_ON = 2;
   localparam int LCR_PD2_GM_M = 1;
   localparam int LCR_PD2_GM_ON = 0;

   // writable masks; reserved positions stay zero
   localparam logic [7:0] LCR_MASK_HYBRID = 8'h77;
   localparam logic [7:0] LCR_MASK_PD1 = 8'h1b;
   localparam logic [7:0] LCR_MASK_PD2 = 8'h3f;
   localparam logic [7:0] LCR_MASK_IRQ1 = 8'h3f;
   localparam logic [7:0] LCR_MASK_IRQ2 = 8'hff;
   localparam logic [7:0] LCR_MASK_IRQ3 = 8'h02;

   // indirect done flag position
   localparam int LCR_IRQ3_IND = 1;

   // reset values
   localparam logic [7:0] LCR_RST_HYBRID = 8'h00;
   localparam logic [7:0] LCR_RST_PD1 = 8'h00;
   localparam logic [7:0] LCR_RST_PD2 = 8'h00;
   localparam logic [7:0] LCR_RST_EN = 8'h00;

   // indirect update rate and clock
   localparam longint LCR_SYS_CLK_HZ = 100000000;
   localparam longint LCR_IND_RATE_HZ = 16000;
   localparam int LCR_IND_TICK_CYCLES = int'(LCR_SYS_CLK_HZ / LCR_IND_RATE_HZ);

   // bus handshake states
   typedef enum logic [1:0] {
      LCR_BUS_IDLE,
      LCR_BUS_ACK,
      LCR_BUS_DONE
   } lcr_bus_state_t;

endpackage

// ===== logic/lcr_sync_edge.sv
// two-flop synchroniser with rising edge pulse per bit
// assumes inputs are asynchronous levels from the analog front end
`timescale 1ns/1ps
module lcr_sync_edge #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] rise_pulse
);

   if (WIDTH < 1) begin : g_bad_width
      $error("lcr_sync_edge width must be at least one");
   end

   logic [WIDTH-1:0] meta_q; // first stage, read only by second
   logic [WIDTH-1:0] sync_q; // second stage
   logic [WIDTH-1:0] last_q; // previous synced level

   // synchroniser and edge history
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // low to high transition of synced level
   assign rise_pulse = sync_q & ~last_q;

endmodule

// ===== logic/lcr_pend_bank.sv
// bank of sticky pending flags, write-one-to-clear
// assumes set and clear are single-cycle strobes on sys_clk
`timescale 1ns/1ps
module lcr_pend_bank #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] set_pulse,
   input wire logic [WIDTH-1:0] clr_pulse,
   output logic [WIDTH-1:0] pend
);

   if (WIDTH < 1) begin : g_bad_width
      $error("lcr_pend_bank width must be at least one");
   end

   logic [WIDTH-1:0] pend_q; // sticky flags

   // one flop per flag
   for (genvar i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            pend_q[i] <= 1'b0;
         end else if (set_pulse[i]) begin
            pend_q[i] <= 1'b1;
         end else if (clr_pulse[i]) begin
            pend_q[i] <= 1'b0;
         end
      end
   end

   assign pend = pend_q;

endmodule

// ===== test/lcr_regs_asserts.sv
// port-level checks of the line codec register group
// assumes one clock, sys_clk, and active low asynchronous rst_n
`timescale 1ns/1ps
module lcr_regs_asserts
   import lcr_pkg::*;
#(
   parameter int TICK_CYCLES = LCR_IND_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic [5:0] timer_events,
   input wire logic [7:0] alarm_line_events,
   input wire logic indirect_request,
   input wire logic adc_auto_on,
   input wire logic dac_auto_on,
   input wire logic transamp_auto_on,
   input wire logic [2:0] metering_hybrid_gain,
   input wire logic [2:0] audio_hybrid_gain,
   input wire logic metering_hybrid_off,
   input wire logic audio_hybrid_off,
   input wire logic converter_force_off,
   input wire logic pll_force_freerun,
   input wire logic bias_force_off,
   input wire logic line_driver_force_off,
   input wire logic adc_power_en,
   input wire logic dac_power_en,
   input wire logic transamp_power_en,
   input wire logic indirect_service
);
   // longest wait allowed from request to service strobe, two cycles above the TICK_CYCLES worst case
   localparam int SVC_MAX = TICK_CYCLES + 2;
   // write taken at its commit edge
   wire logic acc_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
   wire logic wr_pd2 = acc_wr && (avs_address == LCR_IDX_PD2);
   // reserved positions of the addressed hybrid, powerdown, irq 1 or irq 3 register
   wire logic [7:0] rsv_bits = (avs_address == LCR_IDX_HYBRID) ? ~LCR_MASK_HYBRID :
      (avs_address == LCR_IDX_PD1) ? ~LCR_MASK_PD1 : (avs_address == LCR_IDX_PD2) ? ~LCR_MASK_PD2 :
      (avs_address == LCR_IDX_IRQ1) ? ~LCR_MASK_IRQ1 : (avs_address == LCR_IDX_IRQ3) ? ~LCR_MASK_IRQ3 :
      8'h00;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_met_off; metering_hybrid_off == (metering_hybrid_gain == LCR_HYB_OFF); endproperty
   a_met_off: assert property (p_met_off) else $error("metering off flag wrong");
   property p_aud_off; audio_hybrid_off == (audio_hybrid_gain == LCR_HYB_OFF); endproperty
   a_aud_off: assert property (p_aud_off) else $error("audio off flag wrong");
   property p_hyb_wr; acc_wr && avs_address == LCR_IDX_HYBRID |-> ##2
      {metering_hybrid_gain, audio_hybrid_gain} == $past({avs_writedata[6:4], avs_writedata[2:0]}, 2);
   endproperty
   a_hyb_wr: assert property (p_hyb_wr) else $error("hybrid gain fields wrong");
   property p_pd1_wr; acc_wr && avs_address == LCR_IDX_PD1 |-> ##2
      {converter_force_off, pll_force_freerun, bias_force_off, line_driver_force_off}
      == $past({avs_writedata[4:3], avs_writedata[1:0]}, 2);
   endproperty
   a_pd1_wr: assert property (p_pd1_wr) else $error("override outputs wrong");
   property p_adc_man; wr_pd2 && avs_writedata[5] |-> ##2 adc_power_en == $past(avs_writedata[4], 2);
   endproperty
   a_adc_man: assert property (p_adc_man) else $error("adc manual power wrong");
   property p_dac_man; wr_pd2 && avs_writedata[3] |-> ##2 dac_power_en == $past(avs_writedata[2], 2);
   endproperty
   a_dac_man: assert property (p_dac_man) else $error("dac manual power wrong");
   property p_rsv_rd; avs_read && !avs_waitrequest |-> (avs_readdata & {24'hffffff, rsv_bits}) == 0;
   endproperty
   a_rsv_rd: assert property (p_rsv_rd) else $error("reserved bits read nonzero");
   property p_svc_wait; $rose(indirect_request) |-> ##[1:SVC_MAX] indirect_service; endproperty
   a_svc_wait: assert property (p_svc_wait) else $error("indirect request not serviced");
   property p_svc_pulse; indirect_service |=> !indirect_service; endproperty
   a_svc_pulse: assert property (p_svc_pulse) else $error("service strobe too long");
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest [*2]; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus request not answered");
endmodule
bind lcr_regs lcr_regs_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ===== test/tb_top.sv
// self-checking bench for the line codec register group
// assumes lcr_pkg is compiled first and the checker is bound to lcr_regs
`timescale 1ns/1ps
module tb_top
   import lcr_pkg::*;
();
   logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq, indirect_request;
   logic adc_auto_on, dac_auto_on, transamp_auto_on, indirect_service;
   logic [5:0] avs_address, timer_events;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd_q;
   logic [7:0] alarm_line_events, pv;
   logic [2:0] metering_hybrid_gain, audio_hybrid_gain;
   logic metering_hybrid_off, audio_hybrid_off, converter_force_off, pll_force_freerun;
   logic bias_force_off, line_driver_force_off, adc_power_en, dac_power_en, transamp_power_en;
   int fail_count, checked, n;
   // register table and writable masks
   logic [5:0] idx [9] = '{LCR_IDX_HYBRID, LCR_IDX_PD1, LCR_IDX_PD2, LCR_IDX_IRQ1, LCR_IDX_IRQ2,
      LCR_IDX_IRQ3, LCR_IDX_EN1, LCR_IDX_EN2, LCR_IDX_EN3};
   logic [7:0] msk [9] = '{LCR_MASK_HYBRID, LCR_MASK_PD1, LCR_MASK_PD2, 8'h00, 8'h00, 8'h00,
      8'h3f, 8'hff, 8'h02};
   logic [7:0] pd2v [4] = '{8'h00, 8'h15, 8'h2a, 8'h3f};
   // short indirect tick keeps the run brief
   lcr_regs #(.TICK_CYCLES(8)) u_dut (.*);
   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      // wait as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // read and compare the whole data word
   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rd_q, {24'h0, e});
   endtask
   // let registered outputs land
   task automatic settle;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // verdict and end of run
   task automatic summarize;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // watchdog, far beyond the expected run
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'h1;
      avs_writedata = 32'h0;
      timer_events = 6'h00;
      alarm_line_events = 8'h00;
      indirect_request = 1'b0;
      {adc_auto_on, dac_auto_on, transamp_auto_on} = 3'h0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (idx[i]) rdc(idx[i], 8'h00);
      foreach (idx[i]) xfer(1'b1, idx[i], 8'hff);
      foreach (idx[i]) rdc(idx[i], msk[i]);
      xfer(1'b1, 6'h3f, 8'hff);
      rdc(6'h3f, 8'h00);
      avs_byteenable <= 4'h0;
      xfer(1'b1, LCR_IDX_HYBRID, 8'h11);
      avs_byteenable <= 4'h1;
      rdc(LCR_IDX_HYBRID, 8'h77);
      $display("test map done");
      for (int c = 0; c < 8; c++) begin
         xfer(1'b1, LCR_IDX_HYBRID, 8'(c * 16 + 7 - c) | 8'h88);
         settle();
         rdc(LCR_IDX_HYBRID, 8'(c * 16 + 7 - c));
         chk({metering_hybrid_off, metering_hybrid_gain}, {c == 7, 3'(c)});
         chk({audio_hybrid_off, audio_hybrid_gain}, {c == 0, 3'(7 - c)});
      end
      for (int b = 0; b < 5; b++) begin
         xfer(1'b1, LCR_IDX_PD1, 8'(1 << b));
         settle();
         chk({converter_force_off, pll_force_freerun, bias_force_off, line_driver_force_off},
            {b == 4, b == 3, b == 1, b == 0});
      end
      $display("test controls done");
      for (int k = 0; k < 8; k++) begin
         pv = pd2v[k / 2];
         @(posedge sys_clk);
         {adc_auto_on, dac_auto_on, transamp_auto_on} <= {3{k[0]}};
         xfer(1'b1, LCR_IDX_PD2, pv);
         settle();
         chk(adc_power_en, pv[5] ? pv[4] : k[0]);
         chk(dac_power_en, pv[3] ? pv[2] : k[0]);
         chk(transamp_power_en, pv[1] ? pv[0] : k[0]);
      end
      $display("test power done");
      xfer(1'b1, LCR_IDX_EN1, 8'h00);
      @(posedge sys_clk);
      timer_events <= 6'h3f;
      @(posedge sys_clk);
      timer_events <= 6'h00;
      settle();
      chk(irq, 1'b0);
      rdc(LCR_IDX_IRQ1, 8'h3f);
      xfer(1'b1, LCR_IDX_IRQ1, 8'h00);
      rdc(LCR_IDX_IRQ1, 8'h3f);
      xfer(1'b1, LCR_IDX_IRQ1, 8'h01);
      rdc(LCR_IDX_IRQ1, 8'h3e);
      xfer(1'b1, LCR_IDX_EN1, 8'h02);
      settle();
      chk(irq, 1'b1);
      xfer(1'b1, LCR_IDX_IRQ1, 8'h02);
      settle();
      chk(irq, 1'b0);
      @(posedge sys_clk);
      timer_events <= 6'h20;
      xfer(1'b1, LCR_IDX_IRQ1, 8'h3c);
      timer_events <= 6'h00;
      rdc(LCR_IDX_IRQ1, 8'h20);
      $display("test timer flags done");
      @(posedge sys_clk);
      alarm_line_events <= 8'hff;
      settle();
      rdc(LCR_IDX_IRQ2, 8'hff);
      xfer(1'b1, LCR_IDX_IRQ2, 8'h0f);
      rdc(LCR_IDX_IRQ2, 8'hf0);
      xfer(1'b1, LCR_IDX_IRQ2, 8'hf0);
      alarm_line_events <= 8'h00;
      rdc(LCR_IDX_IRQ2, 8'h00);
      $display("test alarm flags done");
      xfer(1'b1, LCR_IDX_EN3, 8'hff);
      @(posedge sys_clk);
      indirect_request <= 1'b1;
      @(posedge sys_clk);
      indirect_request <= 1'b0;
      for (n = 0; n < 40 && indirect_service !== 1'b1; n++) @(posedge sys_clk);
      chk(n <= 8, 1'b1); // served within one 8-cycle tick period
      settle();
      rdc(LCR_IDX_IRQ3, 8'h02);
      chk(irq, 1'b1);
      xfer(1'b1, LCR_IDX_IRQ3, 8'hff);
      rdc(LCR_IDX_IRQ3, 8'h00);
      settle();
      chk(irq, 1'b0);
      $display("test indirect done");
      summarize();
   end
endmodule
